// ===== cefu_event_flags.sv
/*
  event flags 19..14 of the CAN FD controller: dedicated rx buffer store,
  timeout, message ram access failure (rx and tx), timestamp wrap and tx
  event fifo lost/full, read and write-one-to-clear through the register
  port, plus rx/tx abort strobes and the restricted operation bit.
  assumes: register port and handler events synchronous to i_mclk; the
  configuration register elsewhere pulses i_restricted_clr when software
  clears the restricted operation bit.
*/
// Notes on behaviour
// RULE_01: flags live in register 0x1050, reset zero.
// RULE_02: bit 19 sets on dedicated buffer store.
// RULE_03: bit 18 sets only on timeout.
// RULE_04: bit 17 sets on late rx filtering/storage.
// RULE_05: late case aborts storage, next frame proceeds.
// RULE_06: rx ram write failure sets 17, aborts.
// RULE_07: aborted store: no put advance, no newdata.
// RULE_08: aborted location simply overwritten by next store.
// RULE_09: tx fetch failure sets 17, aborts transmission.
// RULE_10: tx fetch failure sets restricted operation bit.
// RULE_11: host clears restricted bit to leave mode.
// RULE_12: bit 16 sets on timestamp wrap to zero.
// RULE_13: bit 15 sets on lost tx event element.
// RULE_14: bit 14 sets when tx event fifo fills.
// RULE_15: flags sticky until host write clears them.
`timescale 1ns/1ps
`default_nettype none

module cefu_event_flags
	import cefu_pkg::*;
(
	// clock and reset
	input  wire logic                      i_mclk,
	input  wire logic                      i_reset_n,
	// register port
	input  wire logic [15:0]               i_reg_addr,
	input  wire logic                      i_reg_wr,
	input  wire logic                      i_reg_rd,
	input  wire logic [31:0]               i_reg_wdata,
	output var  logic [31:0]               o_reg_rdata,
	output var  logic                      o_reg_rd_valid,
	// handler events
	input  wire cefu_evt_t                 i_evt,
	input  wire logic [CEFU_TS_WIDTH-1:0]  i_ts_count,
	input  wire logic                      i_restricted_clr,
	// flag and control outputs
	output var  logic [CEFU_NUM_FLAGS-1:0] o_flags,
	output var  logic                      o_rx_abort,
	output var  logic                      o_rx_fifo_put_adv,
	output var  logic                      o_rx_buf_newdata_set,
	output var  logic                      o_tx_abort,
	output var  logic                      o_restricted_operation_bit
);

	cefu_state_t               st_r;
	cefu_state_t               st_nxt;
	logic [CEFU_NUM_FLAGS-1:0] set_vec;
	logic [CEFU_NUM_FLAGS-1:0] clr_vec;
	logic                      addr_hit;
	logic                      rx_late;
	logic                      rx_abort_now;
	logic                      ts_wrap;
	logic                      tef_lost;
	logic                      tef_full_rise;

	// event decode
	always_comb begin
		addr_hit      = (i_reg_addr == CEFU_EVENT_FLAG_ADDR);
		rx_late       = i_evt.rx_busy & i_evt.rx_arb_field_done;                   // RULE_04
		rx_abort_now  = rx_late | i_evt.rx_ram_wr_fail;                           // RULE_05 RULE_06
		ts_wrap       = (st_r.ts_prev == CEFU_TS_MAX) && (i_ts_count == CEFU_TS_ZERO); // RULE_12
		tef_lost      = i_evt.tef_write_attempt & (i_evt.tef_full | i_evt.tef_size_zero); // RULE_13
		tef_full_rise = i_evt.tef_full & ~st_r.tef_full_prev;                     // RULE_14
	end

	// per-flag set sources
	always_comb begin
		set_vec                = '0;
		set_vec[CEFU_IDX_RXBUF_STORED] = i_evt.rx_dedicated_stored;                // RULE_02
		set_vec[CEFU_IDX_TIMEOUT]      = i_evt.timeout_hit;                        // RULE_03
		set_vec[CEFU_IDX_RAM_FAIL]     = rx_abort_now | i_evt.tx_fetch_fail;       // RULE_04 RULE_06 RULE_09
		set_vec[CEFU_IDX_TS_WRAP]      = ts_wrap;                                  // RULE_12
		set_vec[CEFU_IDX_TEF_LOST]     = tef_lost;                                 // RULE_13
		set_vec[CEFU_IDX_TEF_FULL]     = tef_full_rise;                            // RULE_14
	end

	// write-one-to-clear mask from the register port
	always_comb begin
		clr_vec = '0;
		if (i_reg_wr && addr_hit) begin
			clr_vec = i_reg_wdata[CEFU_FLAG_LSB +: CEFU_NUM_FLAGS];
		end
	end

	// next state
	always_comb begin
		st_nxt = st_r;
		// a set in the same cycle as its clear wins
		st_nxt.flags = (st_r.flags & ~clr_vec) | set_vec;                          // RULE_15

		// read answer from the flags as they stand before this edge
		st_nxt.rd_valid = i_reg_rd;
		st_nxt.rdata    = CEFU_EVENT_FLAG_RESET;
		if (i_reg_rd && addr_hit) begin
			st_nxt.rdata = CEFU_EVENT_FLAG_RESET | (32'(st_r.flags) << CEFU_FLAG_LSB); // RULE_01
		end

		// rx abort strobe tells the handler to drop the frame and take the next
		st_nxt.rx_abort = rx_abort_now;                                            // RULE_05 RULE_06

		// commit only stores that were not aborted; put index stays so the
		// partly written slot is reused by the next store
		st_nxt.rx_fifo_put_adv    = i_evt.rx_store_done & ~rx_abort_now & ~i_evt.rx_store_to_buffer; // RULE_07 RULE_08
		st_nxt.rx_buf_newdata_set = i_evt.rx_store_done & ~rx_abort_now & i_evt.rx_store_to_buffer;  // RULE_07

		// tx fetch failure aborts the transmission
		st_nxt.tx_abort = i_evt.tx_fetch_fail;                                     // RULE_09

		// restricted operation: set by hardware wins over the host clear
		if (i_evt.tx_fetch_fail) begin
			st_nxt.restricted = 1'b1;                                              // RULE_10
		end else if (i_restricted_clr) begin
			st_nxt.restricted = 1'b0;                                              // RULE_11
		end

		// history for edge detection
		st_nxt.ts_prev       = i_ts_count;
		st_nxt.tef_full_prev = i_evt.tef_full;
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_r <= '0;                                                            // RULE_01
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state register
	assign o_flags                    = st_r.flags;
	assign o_reg_rdata                = st_r.rdata;
	assign o_reg_rd_valid             = st_r.rd_valid;
	assign o_rx_abort                 = st_r.rx_abort;
	assign o_rx_fifo_put_adv          = st_r.rx_fifo_put_adv;
	assign o_rx_buf_newdata_set       = st_r.rx_buf_newdata_set;
	assign o_tx_abort                 = st_r.tx_abort;
	assign o_restricted_operation_bit = st_r.restricted;

	// checks on the flag behaviour
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_reset_n);

	a_rxbuf_store_sets: assert property ( // RULE_02
		i_evt.rx_dedicated_stored |=> o_flags[CEFU_IDX_RXBUF_STORED])
		else $error("dedicated buffer store did not set its flag");

	a_timeout_only_event: assert property ( // RULE_03
		(!o_flags[CEFU_IDX_TIMEOUT] && !i_evt.timeout_hit) |=> !o_flags[CEFU_IDX_TIMEOUT])
		else $error("timeout flag set without a timeout");

	a_ramfail_late_rx: assert property ( // RULE_04
		(i_evt.rx_busy && i_evt.rx_arb_field_done) |=> (o_flags[CEFU_IDX_RAM_FAIL] && o_rx_abort))
		else $error("late rx handling did not flag and abort");

	a_rx_fail_abort: assert property ( // RULE_06
		i_evt.rx_ram_wr_fail |=> (o_rx_abort && o_flags[CEFU_IDX_RAM_FAIL]))
		else $error("rx ram write failure not flagged");

	a_abort_no_commit: assert property ( // RULE_07
		o_rx_abort |-> (!o_rx_fifo_put_adv && !o_rx_buf_newdata_set))
		else $error("aborted store was committed");

	a_tx_fail_restrict: assert property ( // RULE_10
		i_evt.tx_fetch_fail |=> (o_tx_abort && o_restricted_operation_bit && o_flags[CEFU_IDX_RAM_FAIL]))
		else $error("tx fetch failure did not abort and restrict");

	a_restrict_hold: assert property ( // RULE_11
		(o_restricted_operation_bit && !i_restricted_clr) |=> o_restricted_operation_bit)
		else $error("restricted bit dropped without host clear");

	// the count history restarts at zero after reset, so no wrap is seen at the first edge
	a_ts_wrap_flag: assert property ( // RULE_12
		($past(i_reset_n) && $past(i_ts_count) == CEFU_TS_MAX && i_ts_count == CEFU_TS_ZERO)
		|=> o_flags[CEFU_IDX_TS_WRAP])
		else $error("timestamp wrap not flagged");

	a_tef_lost_flag: assert property ( // RULE_13
		(i_evt.tef_write_attempt && i_evt.tef_size_zero) |=> o_flags[CEFU_IDX_TEF_LOST])
		else $error("tx event element loss not flagged");

	a_tef_full_flag: assert property ( // RULE_14
		$rose(i_evt.tef_full) |=> o_flags[CEFU_IDX_TEF_FULL])
		else $error("tx event fifo full not flagged");

	a_flag_sticky: assert property ( // RULE_15
		(o_flags != '0 && !(i_reg_wr && i_reg_addr == CEFU_EVENT_FLAG_ADDR))
		|=> ((o_flags & $past(o_flags)) == $past(o_flags)))
		else $error("flag cleared without a register write");

	a_w1c_clears: assert property ( // RULE_15
		(i_reg_wr && i_reg_addr == CEFU_EVENT_FLAG_ADDR && i_reg_wdata[CEFU_TIMEOUT_HIT_BIT] && !i_evt.timeout_hit)
		|=> !o_flags[CEFU_IDX_TIMEOUT])
		else $error("write of one did not clear the timeout flag");

	a_read_value: assert property ( // RULE_01
		(i_reg_rd && i_reg_addr == CEFU_EVENT_FLAG_ADDR)
		|=> (o_reg_rd_valid && o_reg_rdata == (32'($past(o_flags)) << CEFU_FLAG_LSB)))
		else $error("register read returned the wrong value");

	// register port answers
	a_rd_valid_pulse: assert property ( // RULE_01
		i_reg_rd |=> o_reg_rd_valid)
		else $error("read strobe not answered");

	a_idle_rdata_zero: assert property ( // RULE_01
		!i_reg_rd |=> (!o_reg_rd_valid && o_reg_rdata == '0))
		else $error("read answer shown without a read");

	a_foreign_rdata_zero: assert property ( // RULE_01
		(i_reg_rd && i_reg_addr != CEFU_EVENT_FLAG_ADDR) |=> (o_reg_rdata == '0))
		else $error("read of another address returned data");

	a_w1c_rxbuf: assert property ( // RULE_15
		(i_reg_wr && i_reg_addr == CEFU_EVENT_FLAG_ADDR && i_reg_wdata[CEFU_DEDICATED_RXBUF_STORED_BIT]
		&& !i_evt.rx_dedicated_stored) |=> !o_flags[CEFU_IDX_RXBUF_STORED])
		else $error("write of one did not clear the buffer store flag");

	a_set_beats_clear: assert property ( // RULE_15
		(i_reg_wr && i_reg_addr == CEFU_EVENT_FLAG_ADDR && i_reg_wdata[CEFU_TIMEOUT_HIT_BIT] && i_evt.timeout_hit)
		|=> o_flags[CEFU_IDX_TIMEOUT])
		else $error("clear won over a new timeout");

	// flag sources and their absence
	a_rxbuf_only_event: assert property ( // RULE_02
		(!o_flags[CEFU_IDX_RXBUF_STORED] && !i_evt.rx_dedicated_stored) |=> !o_flags[CEFU_IDX_RXBUF_STORED])
		else $error("buffer store flag set without a store");

	a_timeout_sets: assert property ( // RULE_03
		i_evt.timeout_hit |=> o_flags[CEFU_IDX_TIMEOUT])
		else $error("timeout did not set its flag");

	a_ramfail_only_cause: assert property ( // RULE_04
		(!o_flags[CEFU_IDX_RAM_FAIL] && !(i_evt.rx_busy && i_evt.rx_arb_field_done)
		&& !i_evt.rx_ram_wr_fail && !i_evt.tx_fetch_fail) |=> !o_flags[CEFU_IDX_RAM_FAIL])
		else $error("access failure flag set without a cause");

	a_tswrap_only_wrap: assert property ( // RULE_12
		(!o_flags[CEFU_IDX_TS_WRAP] && !($past(i_reset_n) && $past(i_ts_count) == CEFU_TS_MAX
		&& i_ts_count == CEFU_TS_ZERO)) |=> !o_flags[CEFU_IDX_TS_WRAP])
		else $error("timestamp wrap flag set without a wrap");

	a_teflost_on_full: assert property ( // RULE_13
		(i_evt.tef_write_attempt && i_evt.tef_full) |=> o_flags[CEFU_IDX_TEF_LOST])
		else $error("write into a full tx event fifo not flagged");

	a_teflost_only_loss: assert property ( // RULE_13
		(!o_flags[CEFU_IDX_TEF_LOST] && !(i_evt.tef_write_attempt && (i_evt.tef_full || i_evt.tef_size_zero)))
		|=> !o_flags[CEFU_IDX_TEF_LOST])
		else $error("tx event loss flag set without a loss");

	a_teffull_stays_clear: assert property ( // RULE_14
		(!o_flags[CEFU_IDX_TEF_FULL] && !i_evt.tef_full) |=> !o_flags[CEFU_IDX_TEF_FULL])
		else $error("tx event full flag set while space is free");

	// a fifo that was already full does not raise the flag again after a clear
	a_teffull_no_rerise: assert property ( // RULE_14
		(!o_flags[CEFU_IDX_TEF_FULL] && $past(i_reset_n) && $past(i_evt.tef_full))
		|=> !o_flags[CEFU_IDX_TEF_FULL])
		else $error("tx event full flag set again without a new fill");

	// receive handler abort and commit
	a_rx_abort_cause: assert property ( // RULE_05
		(!(i_evt.rx_busy && i_evt.rx_arb_field_done) && !i_evt.rx_ram_wr_fail) |=> !o_rx_abort)
		else $error("rx abort without a cause");

	a_late_no_commit: assert property ( // RULE_07
		(i_evt.rx_busy && i_evt.rx_arb_field_done && i_evt.rx_store_done)
		|=> (!o_rx_fifo_put_adv && !o_rx_buf_newdata_set))
		else $error("late store was committed");

	a_fail_no_commit: assert property ( // RULE_07
		(i_evt.rx_ram_wr_fail && i_evt.rx_store_done) |=> (!o_rx_fifo_put_adv && !o_rx_buf_newdata_set))
		else $error("failed store was committed");

	a_fifo_store_commit: assert property ( // RULE_08
		(i_evt.rx_store_done && !i_evt.rx_store_to_buffer && !i_evt.rx_ram_wr_fail
		&& !(i_evt.rx_busy && i_evt.rx_arb_field_done)) |=> o_rx_fifo_put_adv)
		else $error("clean fifo store did not advance the put index");

	a_buf_store_commit: assert property ( // RULE_07
		(i_evt.rx_store_done && i_evt.rx_store_to_buffer && !i_evt.rx_ram_wr_fail
		&& !(i_evt.rx_busy && i_evt.rx_arb_field_done)) |=> o_rx_buf_newdata_set)
		else $error("clean buffer store did not set new data");

	a_commit_needs_store: assert property ( // RULE_07
		!i_evt.rx_store_done |=> (!o_rx_fifo_put_adv && !o_rx_buf_newdata_set))
		else $error("store committed without a store");

	// transmit failure and restricted operation
	a_tx_abort_cause: assert property ( // RULE_09
		!i_evt.tx_fetch_fail |=> !o_tx_abort)
		else $error("tx abort without a fetch failure");

	a_restrict_cause: assert property ( // RULE_10
		(!o_restricted_operation_bit && !i_evt.tx_fetch_fail) |=> !o_restricted_operation_bit)
		else $error("restricted bit set without a fetch failure");

	a_restrict_leave: assert property ( // RULE_11
		(i_restricted_clr && !i_evt.tx_fetch_fail) |=> !o_restricted_operation_bit)
		else $error("host clear did not leave restricted operation");

endmodule

`default_nettype wire

// ===== cefu_pkg.sv
/*
  package for the upper event-flag slice (bits 19..14) of the CAN FD
  controller event flag register: address, field positions, reset value
  and the grouped event carrier.
  assumes: used by cefu_event_flags and the testbench; one 10 MHz core clock.
*/
`default_nettype none

package cefu_pkg;

	// register map
	localparam logic [15:0] CEFU_EVENT_FLAG_ADDR  = 16'h1050;
	localparam logic [31:0] CEFU_EVENT_FLAG_RESET = 32'h0000_0000;
	localparam int unsigned CEFU_NUM_FLAGS        = 6;

	// field positions inside the 32-bit register
	localparam int unsigned CEFU_DEDICATED_RXBUF_STORED_BIT = 19;
	localparam int unsigned CEFU_TIMEOUT_HIT_BIT            = 18;
	localparam int unsigned CEFU_MSG_RAM_ACCESS_FAIL_BIT    = 17;
	localparam int unsigned CEFU_TIMESTAMP_WRAP_BIT         = 16;
	localparam int unsigned CEFU_TX_EVENT_FIFO_LOST_BIT     = 15;
	localparam int unsigned CEFU_TX_EVENT_FIFO_FULL_BIT     = 14;
	localparam int unsigned CEFU_FLAG_LSB                   = CEFU_TX_EVENT_FIFO_FULL_BIT;

	// index of each flag inside the local six-bit flag vector
	localparam int unsigned CEFU_IDX_RXBUF_STORED = CEFU_DEDICATED_RXBUF_STORED_BIT - CEFU_FLAG_LSB;
	localparam int unsigned CEFU_IDX_TIMEOUT      = CEFU_TIMEOUT_HIT_BIT - CEFU_FLAG_LSB;
	localparam int unsigned CEFU_IDX_RAM_FAIL     = CEFU_MSG_RAM_ACCESS_FAIL_BIT - CEFU_FLAG_LSB;
	localparam int unsigned CEFU_IDX_TS_WRAP      = CEFU_TIMESTAMP_WRAP_BIT - CEFU_FLAG_LSB;
	localparam int unsigned CEFU_IDX_TEF_LOST     = CEFU_TX_EVENT_FIFO_LOST_BIT - CEFU_FLAG_LSB;
	localparam int unsigned CEFU_IDX_TEF_FULL     = CEFU_TX_EVENT_FIFO_FULL_BIT - CEFU_FLAG_LSB;

	// timestamp counter width and its top count
	localparam int unsigned CEFU_TS_WIDTH = 16;
	localparam logic [15:0] CEFU_TS_MAX   = 16'hffff;
	localparam logic [15:0] CEFU_TS_ZERO  = 16'h0000;

	// events reported by the handlers, all one-cycle pulses except levels noted
	typedef struct packed {
		logic rx_dedicated_stored; // frame stored into a dedicated rx buffer
		logic timeout_hit;         // timeout counter reached its condition
		logic rx_busy;             // level: rx handler still filtering or storing
		logic rx_arb_field_done;   // next frame's arbitration field fully received
		logic rx_ram_wr_fail;      // rx handler could not write the message ram
		logic rx_store_done;       // rx handler finished storing a frame
		logic rx_store_to_buffer;  // level: target is a dedicated buffer, not a fifo
		logic tx_fetch_fail;       // tx handler could not read the frame in time
		logic tef_write_attempt;   // tx handler tries to write a tx event element
		logic tef_full;            // level: tx event fifo full
		logic tef_size_zero;       // level: tx event fifo configured with size zero
	} cefu_evt_t;

	// complete module state
	typedef struct packed {
		logic [CEFU_NUM_FLAGS-1:0] flags;
		logic [31:0]               rdata;
		logic                      rd_valid;
		logic                      rx_abort;
		logic                      rx_fifo_put_adv;
		logic                      rx_buf_newdata_set;
		logic                      tx_abort;
		logic                      restricted;
		logic [CEFU_TS_WIDTH-1:0]  ts_prev;
		logic                      tef_full_prev;
	} cefu_state_t;

endpackage

`default_nettype wire

// ===== cefu_testbench.sv
/*
  self-checking testbench for cefu_event_flags: drives the strobe register
  port and handler event pulses, checks flags, strobes and read data.
  assumes: cefu_pkg and cefu_event_flags compiled first; 10 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import cefu_pkg::*;

	logic                      i_mclk, i_reset_n, i_reg_wr, i_reg_rd, i_restricted_clr;
	logic [15:0]               i_reg_addr, i_ts_count;
	logic [31:0]               i_reg_wdata, o_reg_rdata;
	logic                      o_reg_rd_valid, o_rx_abort, o_rx_fifo_put_adv, o_rx_buf_newdata_set;
	logic                      o_tx_abort, o_restricted_operation_bit;
	logic [CEFU_NUM_FLAGS-1:0] o_flags;
	cefu_evt_t                 i_evt, e;
	int                        errors, tests_run, idx[4];

	cefu_event_flags u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rd_valid(o_reg_rd_valid),
		.i_evt(i_evt), .i_ts_count(i_ts_count), .i_restricted_clr(i_restricted_clr), .o_flags(o_flags),
		.o_rx_abort(o_rx_abort), .o_rx_fifo_put_adv(o_rx_fifo_put_adv), .o_rx_buf_newdata_set(o_rx_buf_newdata_set),
		.o_tx_abort(o_tx_abort), .o_restricted_operation_bit(o_restricted_operation_bit));

	// core clock, 100 ns period
	initial begin
		i_mclk = 1'b0;
		forever #50 i_mclk = ~i_mclk;
	end

	// compare one value and count it
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// single verdict point for the whole run
	task automatic stop_test;
		if (errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one edge, then settle just after it
	task automatic tick;
		@(posedge i_mclk);
		#10;
	endtask

	// one-cycle event pulse after an idle edge; strobes are sampled on return
	task automatic step(input cefu_evt_t ev);
		tick();
		i_evt = ev;
		tick();
		i_evt = '0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		i_reg_addr  = a;
		i_reg_wdata = d;
		i_reg_wr    = 1'b1;
		tick();
		i_reg_wr    = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		i_reg_addr = a;
		i_reg_rd   = 1'b1;
		tick();
		i_reg_rd   = 1'b0;
		chk("rd_valid", 32'(o_reg_rd_valid), 32'h1);
		chk("rdata", o_reg_rdata, x);
		tick();
		chk("rd_valid end", 32'(o_reg_rd_valid), 32'h0);
	endtask

	// word value of one flag index inside the register
	function automatic logic [31:0] fw(input int k);
		return 32'h1 << (CEFU_FLAG_LSB + k);
	endfunction

	// single-source event for the table-driven flag tests
	function automatic cefu_evt_t one(input int k);
		one = '0;
		case (k)
			0: one.rx_dedicated_stored = 1'b1;
			1: one.timeout_hit = 1'b1;
			2: begin
				one.tef_write_attempt = 1'b1;
				one.tef_size_zero     = 1'b1;
			end
			default: one.tef_full = 1'b1;
		endcase
	endfunction

	// watchdog for a hung run
	initial begin
		#(3000 * 100);
		errors++;
		stop_test();
	end

	// main sequence
	initial begin
		{i_reg_wr, i_reg_rd, i_restricted_clr, i_reg_addr, i_reg_wdata, i_ts_count} = '0;
		i_evt = '0;
		i_reset_n = 1'b0;
		idx = '{CEFU_IDX_RXBUF_STORED, CEFU_IDX_TIMEOUT, CEFU_IDX_TEF_LOST, CEFU_IDX_TEF_FULL};
		repeat (5) @(posedge i_mclk);
		#10;
		i_reset_n = 1'b1;
		tick();
		rd(CEFU_EVENT_FLAG_ADDR, CEFU_EVENT_FLAG_RESET);
		// buffer store, timeout, tef lost and tef full flags each set, read back alone, then clear by write-one
		for (int k = 0; k < 4; k++) begin
			step(one(k));
			chk("flags", 32'(o_flags), fw(idx[k]) >> CEFU_FLAG_LSB);
			rd(16'h104c, 32'h0);
			rd(CEFU_EVENT_FLAG_ADDR, fw(idx[k]));
			wr(CEFU_EVENT_FLAG_ADDR, fw(idx[k]));
			chk("flag clear", 32'(o_flags), 32'h0);
		end
		// timestamp wrap from top count to zero
		i_ts_count = CEFU_TS_MAX;
		tick();
		i_ts_count = CEFU_TS_ZERO;
		tick();
		rd(CEFU_EVENT_FLAG_ADDR, fw(CEFU_IDX_TS_WRAP));
		// set wins over a clear in the same cycle; foreign address ignored
		i_evt = one(1);
		wr(CEFU_EVENT_FLAG_ADDR, 32'hffff_ffff);
		i_evt = '0;
		rd(CEFU_EVENT_FLAG_ADDR, fw(CEFU_IDX_TIMEOUT));
		wr(16'h1054, 32'hffff_ffff);
		rd(CEFU_EVENT_FLAG_ADDR, fw(CEFU_IDX_TIMEOUT));
		wr(CEFU_EVENT_FLAG_ADDR, 32'hffff_ffff);
		// write while the tx event fifo is full is lost; full flag stays clear once cleared
		e = '0;
		e.tef_full = 1'b1;
		i_evt = e;
		tick();
		wr(CEFU_EVENT_FLAG_ADDR, fw(CEFU_IDX_TEF_FULL));
		e.tef_write_attempt = 1'b1;
		i_evt = e;
		tick();
		i_evt = '0;
		chk("flags", 32'(o_flags), fw(CEFU_IDX_TEF_LOST) >> CEFU_FLAG_LSB);
		wr(CEFU_EVENT_FLAG_ADDR, fw(CEFU_IDX_TEF_LOST));
		// tx fetch failure: abort, access flag, restricted mode
		e = '0;
		e.tx_fetch_fail = 1'b1;
		step(e);
		chk("tx_abort", 32'(o_tx_abort), 32'h1);
		chk("restricted", 32'(o_restricted_operation_bit), 32'h1);
		chk("flags", 32'(o_flags), fw(CEFU_IDX_RAM_FAIL) >> CEFU_FLAG_LSB);
		tick();
		chk("tx_abort end", 32'(o_tx_abort), 32'h0);
		chk("restricted hold", 32'(o_restricted_operation_bit), 32'h1);
		i_restricted_clr = 1'b1;
		tick();
		i_restricted_clr = 1'b0;
		chk("restricted clr", 32'(o_restricted_operation_bit), 32'h0);
		wr(CEFU_EVENT_FLAG_ADDR, fw(CEFU_IDX_RAM_FAIL));
		// late rx handling into a dedicated buffer: abort, no new data
		e = '0;
		{e.rx_busy, e.rx_arb_field_done, e.rx_store_done, e.rx_store_to_buffer} = 4'hf;
		step(e);
		chk("rx_abort", 32'(o_rx_abort), 32'h1);
		chk("newdata", 32'(o_rx_buf_newdata_set), 32'h0);
		chk("flags", 32'(o_flags), fw(CEFU_IDX_RAM_FAIL) >> CEFU_FLAG_LSB);
		wr(CEFU_EVENT_FLAG_ADDR, fw(CEFU_IDX_RAM_FAIL));
		// ram write failure on a fifo store: abort, put index held
		e = '0;
		{e.rx_ram_wr_fail, e.rx_store_done} = 2'h3;
		step(e);
		chk("rx_abort", 32'(o_rx_abort), 32'h1);
		chk("put_adv", 32'(o_rx_fifo_put_adv), 32'h0);
		chk("flags", 32'(o_flags), fw(CEFU_IDX_RAM_FAIL) >> CEFU_FLAG_LSB);
		// next fifo store goes ahead normally at the same location, then a buffer store sets new data
		e = '0;
		e.rx_store_done = 1'b1;
		step(e);
		chk("put_adv", 32'(o_rx_fifo_put_adv), 32'h1);
		chk("rx_abort", 32'(o_rx_abort), 32'h0);
		e.rx_store_to_buffer = 1'b1;
		step(e);
		chk("newdata", 32'(o_rx_buf_newdata_set), 32'h1);
		stop_test();
	end
endmodule

`default_nettype wire
